// >>> hdl/ess_pkg.sv
package ess_pkg;
    // Timebase: all setting timers count tenths of a second
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COOL = 8'h04;
    localparam logic [7:0] ADDR_SFAIL = 8'h08;
    localparam logic [7:0] ADDR_EXT = 8'h0C;
    localparam logic [7:0] ADDR_THR = 8'h10;
    localparam logic [7:0] ADDR_RUNLVL = 8'h14;
    localparam logic [7:0] ADDR_GOVOFS = 8'h18;
    localparam logic [7:0] ADDR_CRANK = 8'h1C;
    localparam logic [7:0] ADDR_RUNFB = 8'h20;
    localparam logic [7:0] ADDR_FV = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_ALARM = 8'h2C;

    // Setting limits and reset values (cooldown in s, timers in 0.1 s)
    localparam logic [15:0] COOL_MAX_S = 16'h26AC;
    localparam logic [15:0] COOL_DEF_S = 16'h00F0;
    localparam logic [15:0] SF_MIN_DS = 16'h0064;
    localparam logic [15:0] SF_MAX_DS = 16'h04B0;
    localparam logic [15:0] SF_DEF_DS = 16'h012C;
    localparam logic [15:0] EXT_MIN_DS = 16'h000A;
    localparam logic [15:0] EXT_MAX_DS = 16'h03DE;
    localparam logic [15:0] EXT_DEF_DS = 16'h0032;
    localparam logic [8:0] THR_MAX = 9'h1E2;
    localparam logic [8:0] THR_DEF = 9'h000;
    localparam logic [15:0] DLY_MIN_DS = 16'h000A;
    localparam logic [15:0] DLY_MAX_DS = 16'h03DE;
    localparam logic [15:0] CRANK_DEF_DS = 16'h0064;
    localparam logic [15:0] RUNFB_DEF_DS = 16'h0064;
    localparam logic [15:0] FV_DEF_DS = 16'h012C;
    localparam logic [15:0] RUNLVL_DEF = 16'h012C;
    localparam logic [15:0] GOVOFS_DEF = 16'h0000;

    // Field codes
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_SEMI = 2'h1;
    localparam logic [1:0] MODE_MANUAL = 2'h2;
    localparam logic [1:0] MODE_BLOCK = 2'h3;
    localparam logic [2:0] PLANT_MPE = 3'h3;
    localparam logic [2:0] PLANT_PEAK = 3'h4;
    localparam logic [2:0] THR_SRC_USER = 3'h4;
    localparam logic [2:0] THR_SRC_EBUS = 3'h5;
    localparam logic [3:0] FC_SHUTDOWN = 4'h4;
    localparam logic [3:0] FC_MAX = 4'h8;
    localparam int unsigned AL_CRANK = 0;
    localparam int unsigned AL_RUNFB = 1;
    localparam int unsigned AL_FV = 2;
    localparam int unsigned AL_EXTSTOP = 3;
    localparam int unsigned AL_STOPFAIL = 4;
    localparam int unsigned AL_N = 5;

    typedef struct packed {
        logic [3:0] fail_class;
        logic stop_fail_en;
        logic pickup_primary;
        logic mode_shift;
        logic mains_loss_auto_start;
        logic [2:0] plant;
        logic [1:0] mode;
    } ess_ctrl_t;

    localparam ess_ctrl_t CTRL_RESET = '{fail_class: FC_SHUTDOWN, stop_fail_en: 1'b1,
        pickup_primary: 1'b1, mode_shift: 1'b0, mains_loss_auto_start: 1'b0,
        plant: 3'h0, mode: MODE_SEMI};

    typedef struct packed {
        logic stop_btn;
        logic estop;
        logic auto_stop;
        logic trip_stop;
        logic auto_req;
        logic mains_loss;
        logic start_btn;
        logic remote_start;
        logic digital_start;
        logic peak_exceed;
        logic generator_breaker_close_req;
        logic primary_fb;
        logic secondary_fb;
        logic freq_level_ok;
        logic freq_volt_window_ok;
    } ess_pins_t;

    typedef enum logic [2:0] {ST_STOPPED, ST_RUNNING, ST_COOLDOWN, ST_STOPPING, ST_EXTSTOP}
        ess_state_t;
endpackage

// >>> hdl/ess_top.sv
// Behaviour
// [R1] Stop command runs stop sequence; normal or controlled stops cool down first.
// [R2] Cooldown setting 0 to 9900 s, default 240 s.
// [R3] Cooldown setting zero means endless cooldown, no automatic stop.
// [R4] Emergency stop skips cooldown, opens generator breaker, shuts engine at once.
// [R5] Semi/manual stop button starts stop; second press ends cooldown early.
// [R6] Auto stop, trip-and-stop, or removed auto request cool down then stop.
// [R7] Stop sequence abortable only during cooldown; afterwards it completes.
// [R8] No new start while stopping, until engine fully stopped.
// [R9] Listed mains, start, peak and breaker events abort cooldown.
// [R10] Engine stopped returns governor output to configured offset.
// [R11] Stop-failure timer 10.0 to 120.0 s, default 30.0 s.
// [R12] Stop-failure alarm enable defaults on; fail class defaults shutdown.
// [R13] Extended-stop timer 1.0 to 99.0 s, default 5.0 s.
// [R14] Stop threshold source selectable; value 0 to 482, default 0.
// [R15] Pickup primary: crank failure if speed level not reached within delay.
// [R16] Secondary feedback running without primary raises run feedback failure after delay.
// [R17] After running feedback, window outside limits raises freq/volt failure.
// [R18] Running, below both levels, not commanded: engine externally stopped alarm.
// [R19] Running detection level is a configurable speed set point.
// [R20] Stop failure alarm when engine still runs at stop-failure timer expiry.
`timescale 1ns/1ps
`default_nettype none
module ess_top #(
    parameter int unsigned TICK_CYCLES = ess_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Discrete pins from engine, breakers and operator
    input wire ess_pkg::ess_pins_t pins_i,
    // Measurements from same-clock logic
    input wire logic [15:0] speed_i,
    input wire logic [3:0][8:0] multi_in_i,
    input wire logic [8:0] user_val_i,
    input wire logic [8:0] ebus_temp_i,
    input wire logic [15:0] gov_cmd_i,
    // Engine and breaker control
    output logic run_request_o,
    output logic stop_coil_o,
    output logic generator_breaker_open_o,
    output logic cooldown_o,
    output logic start_inhibit_o,
    output logic [15:0] gov_out_o,
    // Alarms
    output logic [4:0] alarm_o,
    output logic [3:0] stop_fail_class_o
);
    initial
    begin
        if (TICK_CYCLES < 1)
        begin
            $error("TICK_CYCLES must be at least 1");
        end
    end

    // Pin synchroniser and edge detect
    ess_pkg::ess_pins_t s1_q, s2_q, s3_q;
    always_ff @(posedge clk_i)
    begin
        s1_q <= pins_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    ess_pkg::ess_pins_t rise;
    assign rise = ess_pkg::ess_pins_t'(s2_q & ~s3_q);
    wire logic auto_req_fall = s3_q.auto_req & ~s2_q.auto_req;

    // Registers
    ess_pkg::ess_ctrl_t ctrl_q;
    logic [15:0] cool_q, sf_q, ext_q, runlvl_q, govofs_q;
    logic [15:0] crank_q, runfb_q, fv_q;
    logic [2:0] thr_src_q;
    logic [8:0] thr_val_q;
    logic [4:0] alarm_q;
    logic ack_q;
    logic [31:0] rd_q;
    ess_pkg::ess_state_t st_q, st_d;

    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic wr_en = req & wb_we_i & ack_q;
    wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
            input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo,
            input logic [15:0] hi);
        if (v[15:0] < lo)
            clamp = lo;
        else if (v > {16'h0000, hi})
            clamp = hi;
        else
            clamp = v[15:0];
    endfunction

    wire logic [31:0] m_ctrl = merge({19'h00000, ctrl_q}, wb_dat_i, wmask);
    wire logic [31:0] m_cool = merge({16'h0000, cool_q}, wb_dat_i, wmask);
    wire logic [31:0] m_sf = merge({16'h0000, sf_q}, wb_dat_i, wmask);
    wire logic [31:0] m_ext = merge({16'h0000, ext_q}, wb_dat_i, wmask);
    wire logic [31:0] m_thr = merge({20'h00000, thr_src_q, thr_val_q}, wb_dat_i, wmask);
    wire logic [31:0] m_rl = merge({16'h0000, runlvl_q}, wb_dat_i, wmask);
    wire logic [31:0] m_go = merge({16'h0000, govofs_q}, wb_dat_i, wmask);
    wire logic [31:0] m_cr = merge({16'h0000, crank_q}, wb_dat_i, wmask);
    wire logic [31:0] m_rf = merge({16'h0000, runfb_q}, wb_dat_i, wmask);
    wire logic [31:0] m_fv = merge({16'h0000, fv_q}, wb_dat_i, wmask);
    wire logic [3:0] fc_w = (m_ctrl[12:9] > ess_pkg::FC_MAX) ? ess_pkg::FC_SHUTDOWN : m_ctrl[12:9];
    wire logic [2:0] src_w = (m_thr[11:9] > ess_pkg::THR_SRC_EBUS) ? 3'h0 : m_thr[11:9];
    wire logic [8:0] thrv_w = (m_thr[8:0] > ess_pkg::THR_MAX) ? ess_pkg::THR_MAX : m_thr[8:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= ess_pkg::CTRL_RESET; // [R12]
            cool_q <= ess_pkg::COOL_DEF_S; // [R2]
            sf_q <= ess_pkg::SF_DEF_DS; // [R11]
            ext_q <= ess_pkg::EXT_DEF_DS; // [R13]
            thr_src_q <= 3'h0; // [R14]
            thr_val_q <= ess_pkg::THR_DEF;
            runlvl_q <= ess_pkg::RUNLVL_DEF;
            govofs_q <= ess_pkg::GOVOFS_DEF;
            crank_q <= ess_pkg::CRANK_DEF_DS;
            runfb_q <= ess_pkg::RUNFB_DEF_DS;
            fv_q <= ess_pkg::FV_DEF_DS;
        end
        else if (wr_en)
        begin
            unique case (wb_adr_i)
                ess_pkg::ADDR_CTRL: ctrl_q <= ess_pkg::ess_ctrl_t'({fc_w, m_ctrl[8:0]});
                ess_pkg::ADDR_COOL: cool_q <= clamp(m_cool, 16'h0000, ess_pkg::COOL_MAX_S); // [R2]
                ess_pkg::ADDR_SFAIL: sf_q <= clamp(m_sf, ess_pkg::SF_MIN_DS, ess_pkg::SF_MAX_DS); // [R11]
                ess_pkg::ADDR_EXT: ext_q <= clamp(m_ext, ess_pkg::EXT_MIN_DS, ess_pkg::EXT_MAX_DS); // [R13]
                ess_pkg::ADDR_THR:
                begin
                    thr_src_q <= src_w; // [R14]
                    thr_val_q <= thrv_w;
                end
                ess_pkg::ADDR_RUNLVL: runlvl_q <= m_rl[15:0]; // [R19]
                ess_pkg::ADDR_GOVOFS: govofs_q <= m_go[15:0];
                ess_pkg::ADDR_CRANK: crank_q <= clamp(m_cr, ess_pkg::DLY_MIN_DS, ess_pkg::DLY_MAX_DS);
                ess_pkg::ADDR_RUNFB: runfb_q <= clamp(m_rf, ess_pkg::DLY_MIN_DS, ess_pkg::DLY_MAX_DS);
                ess_pkg::ADDR_FV: fv_q <= clamp(m_fv, ess_pkg::DLY_MIN_DS, ess_pkg::DLY_MAX_DS);
                default:
                begin
                end
            endcase
        end
    end

    // Tenth-second tick
    logic [31:0] pre_q;
    wire logic tick = (pre_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick)
            pre_q <= 32'h00000000;
        else
            pre_q <= pre_q + 32'h00000001;
    end

    // Engine status
    wire logic speed_hit = (speed_i >= runlvl_q); // [R19]
    wire logic prim_run = ctrl_q.pickup_primary ? speed_hit : s2_q.primary_fb;
    wire logic eng_run = prim_run | s2_q.freq_level_ok;
    wire logic m_auto = (ctrl_q.mode == ess_pkg::MODE_AUTO);
    wire logic m_semi = (ctrl_q.mode == ess_pkg::MODE_SEMI);
    wire logic m_man = (ctrl_q.mode == ess_pkg::MODE_MANUAL);
    wire logic plant_ok = (ctrl_q.plant <= ess_pkg::PLANT_MPE);
    wire logic plant_peak = (ctrl_q.plant == ess_pkg::PLANT_PEAK);
    wire logic mains_go = m_auto & s2_q.mains_loss &
        (ctrl_q.mains_loss_auto_start | ctrl_q.mode_shift);

    // Start, stop and abort decode
    wire logic start_req = (m_auto & ((s2_q.auto_req & plant_ok) | mains_go |
        (s2_q.digital_start & plant_ok) | (s2_q.peak_exceed & plant_peak))) |
        (m_semi & (rise.start_btn | rise.remote_start)) | (m_man & rise.start_btn);
    wire logic stop_req = (m_auto & (s2_q.auto_stop | (auto_req_fall & plant_ok))) | // [R6]
        s2_q.trip_stop | ((m_semi | m_man) & rise.stop_btn); // [R5]
    wire logic estop = s2_q.estop;
    wire logic second_press = (m_semi | m_man) & rise.stop_btn; // [R5]
    wire logic abort_cd = mains_go | (m_semi & (rise.start_btn | rise.remote_start)) | // [R9]
        (m_auto & s2_q.digital_start & plant_ok) | (m_auto & s2_q.peak_exceed & plant_peak) |
        (m_semi & rise.generator_breaker_close_req);

    // Stop threshold source
    logic [8:0] thr_sel;
    assign thr_sel = (thr_src_q == ess_pkg::THR_SRC_USER) ? user_val_i :
        (thr_src_q == ess_pkg::THR_SRC_EBUS) ? ebus_temp_i : multi_in_i[thr_src_q[1:0]]; // [R14]
    wire logic thr_hit = (thr_val_q != 9'h000) & (thr_sel < thr_val_q);

    // Sequence timer
    logic [16:0] seq_q;
    logic seen_run_q;
    wire logic [16:0] cool_ds = 17'(cool_q) * 17'h0000A;
    wire logic cd_done = (cool_q != 16'h0000) & (seq_q >= cool_ds); // [R3]
    wire logic ext_done = (seq_q >= 17'(ext_q));
    wire logic ext_stopped = seen_run_q & (st_q == ess_pkg::ST_RUNNING ||
        st_q == ess_pkg::ST_COOLDOWN) & ~speed_hit & ~s2_q.freq_level_ok; // [R18]

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ess_pkg::ST_STOPPED:
                if (start_req)
                    st_d = ess_pkg::ST_RUNNING;
            ess_pkg::ST_RUNNING:
                if (estop)
                    st_d = ess_pkg::ST_STOPPING; // [R4]
                else if (ext_stopped)
                    st_d = ess_pkg::ST_STOPPED;
                else if (stop_req)
                    st_d = ess_pkg::ST_COOLDOWN; // [R1]
            ess_pkg::ST_COOLDOWN:
                if (estop || second_press || cd_done || thr_hit)
                    st_d = ess_pkg::ST_STOPPING; // [R5]
                else if (ext_stopped)
                    st_d = ess_pkg::ST_STOPPED;
                else if (abort_cd)
                    st_d = ess_pkg::ST_RUNNING; // [R7]
            ess_pkg::ST_STOPPING:
                if (!eng_run)
                    st_d = ess_pkg::ST_EXTSTOP; // [R7]
            ess_pkg::ST_EXTSTOP:
                if (ext_done)
                    st_d = ess_pkg::ST_STOPPED; // [R8]
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ess_pkg::ST_STOPPED;
            seq_q <= 17'h00000;
            seen_run_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            if (st_d != st_q)
                seq_q <= 17'h00000;
            else if (tick && seq_q != 17'h1FFFF)
                seq_q <= seq_q + 17'h00001;
            seen_run_q <= (st_d == ess_pkg::ST_RUNNING || st_d == ess_pkg::ST_COOLDOWN) &
                (seen_run_q | eng_run);
        end
    end

    // Alarm delay timers: crank, run feedback, freq/volt window
    logic [2:0] al_cond;
    logic [2:0][15:0] al_lim;
    logic [2:0] al_ev;
    wire logic run_seq = (st_q == ess_pkg::ST_RUNNING);
    assign al_cond[ess_pkg::AL_CRANK] = ctrl_q.pickup_primary & run_seq & ~speed_hit; // [R15]
    assign al_cond[ess_pkg::AL_RUNFB] = s2_q.secondary_fb & ~prim_run; // [R16]
    assign al_cond[ess_pkg::AL_FV] = run_seq & eng_run & ~s2_q.freq_volt_window_ok; // [R17]
    assign al_lim[ess_pkg::AL_CRANK] = crank_q;
    assign al_lim[ess_pkg::AL_RUNFB] = runfb_q;
    assign al_lim[ess_pkg::AL_FV] = fv_q;
    for (genvar g = 0; g < 3; g++)
    begin : g_dly
        logic [15:0] cnt_q;
        always_ff @(posedge clk_i)
        begin
            if (rst_i || !al_cond[g])
                cnt_q <= 16'h0000;
            else if (tick && cnt_q < al_lim[g])
                cnt_q <= cnt_q + 16'h0001;
        end
        assign al_ev[g] = al_cond[g] & (cnt_q >= al_lim[g]);
    end

    // Stop failure supervision
    logic [15:0] sf_cnt_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_q != ess_pkg::ST_STOPPING)
            sf_cnt_q <= 16'h0000;
        else if (tick && sf_cnt_q < sf_q)
            sf_cnt_q <= sf_cnt_q + 16'h0001;
    end
    wire logic sf_ev = ctrl_q.stop_fail_en & (st_q == ess_pkg::ST_STOPPING) &
        (sf_cnt_q >= sf_q) & eng_run; // [R20]

    // Sticky alarms, write one to clear, new event wins
    wire logic [4:0] al_set = {sf_ev, ext_stopped, al_ev};
    wire logic [4:0] al_clr = (wr_en && wb_adr_i == ess_pkg::ADDR_ALARM) ?
        (wb_dat_i[4:0] & {5{wb_sel_i[0]}}) : 5'h00;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alarm_q <= 5'h00;
        else
            alarm_q <= (alarm_q & ~al_clr) | al_set;
    end

    // Outputs
    logic [15:0] gov_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gov_q <= ess_pkg::GOVOFS_DEF;
        else
            gov_q <= (st_q == ess_pkg::ST_STOPPED) ? govofs_q : gov_cmd_i; // [R10]
    end
    assign gov_out_o = gov_q;
    assign run_request_o = (st_q == ess_pkg::ST_RUNNING) | (st_q == ess_pkg::ST_COOLDOWN);
    assign stop_coil_o = (st_q == ess_pkg::ST_STOPPING) | (st_q == ess_pkg::ST_EXTSTOP); // [R4]
    assign generator_breaker_open_o = (st_q == ess_pkg::ST_COOLDOWN) | stop_coil_o; // [R4]
    assign cooldown_o = (st_q == ess_pkg::ST_COOLDOWN);
    assign start_inhibit_o = stop_coil_o; // [R8]
    assign alarm_o = alarm_q;
    assign stop_fail_class_o = ctrl_q.fail_class; // [R12]

    // Read mux and Wishbone answer
    logic [31:0] rd_mux;
    assign rd_mux =
        (wb_adr_i == ess_pkg::ADDR_CTRL) ? {19'h00000, ctrl_q} :
        (wb_adr_i == ess_pkg::ADDR_COOL) ? {16'h0000, cool_q} :
        (wb_adr_i == ess_pkg::ADDR_SFAIL) ? {16'h0000, sf_q} :
        (wb_adr_i == ess_pkg::ADDR_EXT) ? {16'h0000, ext_q} :
        (wb_adr_i == ess_pkg::ADDR_THR) ? {20'h00000, thr_src_q, thr_val_q} :
        (wb_adr_i == ess_pkg::ADDR_RUNLVL) ? {16'h0000, runlvl_q} :
        (wb_adr_i == ess_pkg::ADDR_GOVOFS) ? {16'h0000, govofs_q} :
        (wb_adr_i == ess_pkg::ADDR_CRANK) ? {16'h0000, crank_q} :
        (wb_adr_i == ess_pkg::ADDR_RUNFB) ? {16'h0000, runfb_q} :
        (wb_adr_i == ess_pkg::ADDR_FV) ? {16'h0000, fv_q} :
        (wb_adr_i == ess_pkg::ADDR_STATUS) ? {7'h00, seq_q, 3'h0, seen_run_q,
            eng_run, st_q} :
        (wb_adr_i == ess_pkg::ADDR_ALARM) ? {27'h0000000, alarm_q} : 32'h00000000;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rd_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q)
                rd_q <= rd_mux;
        end
    end
    assign wb_ack_o = ack_q & req;
    assign wb_dat_o = rd_q;

    // Checks
    estop_skip_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        (st_q == ess_pkg::ST_RUNNING && estop) |=> st_q == ess_pkg::ST_STOPPING && stop_coil_o)
        else $error("emergency stop did not stop at once");
    cool_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        (st_q == ess_pkg::ST_RUNNING && stop_req && !estop && !ext_stopped)
        |=> cooldown_o && run_request_o)
        else $error("normal stop skipped cooldown");
    cool_endless_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        (st_q == ess_pkg::ST_COOLDOWN && cool_q == 16'h0000 && !estop && !second_press &&
        !thr_hit && !abort_cd && !ext_stopped) |=> st_q == ess_pkg::ST_COOLDOWN)
        else $error("zero cooldown ended on its own");
    second_press_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        (st_q == ess_pkg::ST_COOLDOWN && second_press) |=> st_q == ess_pkg::ST_STOPPING)
        else $error("second stop press did not end cooldown");
    no_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
        (st_q == ess_pkg::ST_STOPPING) |=> st_q inside {ess_pkg::ST_STOPPING,
        ess_pkg::ST_EXTSTOP})
        else $error("stop aborted after cooldown");
    start_lock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        start_inhibit_o |=> !(st_q == ess_pkg::ST_RUNNING))
        else $error("start taken while stopping");
    cd_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
        (st_q == ess_pkg::ST_COOLDOWN && abort_cd && !estop && !second_press && !cd_done &&
        !thr_hit && !ext_stopped) |=> st_q == ess_pkg::ST_RUNNING)
        else $error("cooldown abort ignored");
    gov_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        (st_q == ess_pkg::ST_STOPPED) ##1 (st_q == ess_pkg::ST_STOPPED)
        |-> gov_out_o == $past(govofs_q))
        else $error("governor not at offset when stopped");
    set_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        sf_q >= ess_pkg::SF_MIN_DS && sf_q <= ess_pkg::SF_MAX_DS &&
        ext_q >= ess_pkg::EXT_MIN_DS && ext_q <= ess_pkg::EXT_MAX_DS &&
        cool_q <= ess_pkg::COOL_MAX_S && thr_val_q <= ess_pkg::THR_MAX)
        else $error("setting outside range");
    stop_fail_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
        sf_ev |=> alarm_o[ess_pkg::AL_STOPFAIL])
        else $error("stop failure not raised");
    ext_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        ext_stopped |=> alarm_o[ess_pkg::AL_EXTSTOP] && !run_request_o)
        else $error("external stop not flagged");
endmodule
`default_nettype wire

// >>> sim/ess_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ess_engine_model (
    // Clock
    input wire logic clk_i,
    // Controller and bench commands
    input wire logic run_i,
    input wire logic stop_i,
    input wire logic stuck_i,
    // Feedback
    output logic fb_o,
    output logic [15:0] speed_o
);
    // Spins up under run request, coasts down otherwise; stuck keeps it turning
    logic [4:0] spin_q = 5'h00;
    always_ff @(posedge clk_i)
        if ((run_i && !stop_i) || stuck_i)
            spin_q <= (spin_q == 5'h1F) ? spin_q : spin_q + 5'h01;
        else
            spin_q <= (spin_q == 5'h00) ? spin_q : spin_q - 5'h01;
    assign speed_o = {4'h0, spin_q, 7'h00};
    assign fb_o = spin_q > 5'h10;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, stuck = 0, fb, ack, run, coil, gbo, cool, inh;
    logic win = 1;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, rd, dout;
    logic [10:0] op = 0;
    logic [15:0] spd, gov = 16'h0123, gout;
    logic [4:0] alarm;
    logic [3:0] fcls;
    int failures = 0, n_tests = 0;
    wire logic [4:0] sig = {alarm[4], coil, cool, run, fb};
    ess_pkg::ess_pins_t pins;
    assign pins = {op, fb, fb, fb, win};
    ess_top #(.TICK_CYCLES(10)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .pins_i(pins), .speed_i(spd), .multi_in_i('0), .user_val_i(9'h000),
        .ebus_temp_i(9'h000), .gov_cmd_i(gov), .run_request_o(run), .stop_coil_o(coil),
        .generator_breaker_open_o(gbo), .cooldown_o(cool), .start_inhibit_o(inh),
        .gov_out_o(gout), .alarm_o(alarm), .stop_fail_class_o(fcls));
    ess_engine_model eng (.clk_i(clk), .run_i(run), .stop_i(coil), .stuck_i(stuck), .fb_o(fb),
        .speed_o(spd));
    initial
        forever #10 clk = ~clk;
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for one watched output to reach a level
    task wt(input int k, input logic v, input int n);
        for (int i = 0; i < n && sig[k] !== v; i++)
            @(posedge clk);
        chk(sig[k], v);
        if (sig[k] !== v)
            report_and_stop;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        for (int i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge clk);
        if (ack !== 1'b1)
        begin
            failures++;
            report_and_stop;
        end
        rd = dout;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        wb(0, a, 32'h0);
        chk(rd, e);
    endtask
    task press(input int k);
        op[k] <= 1;
        repeat (6) @(posedge clk);
        op[k] <= 0;
        repeat (6) @(posedge clk);
    endtask
    task t_reset;
        rc(ess_pkg::ADDR_COOL, 32'hF0);
        rc(ess_pkg::ADDR_SFAIL, 32'h12C);
        rc(ess_pkg::ADDR_EXT, 32'h32);
        rc(ess_pkg::ADDR_CTRL, 32'h981);
        rc(8'h30, 32'h0);
        chk(fcls, 4'h4);
        wb(1, ess_pkg::ADDR_THR, 32'h1E3);
        rc(ess_pkg::ADDR_THR, 32'h1E2);
        wb(1, ess_pkg::ADDR_THR, 32'h0);
        wb(1, ess_pkg::ADDR_COOL, 32'h2710);
        rc(ess_pkg::ADDR_COOL, 32'h26AC);
    endtask
    task t_stop;
        wb(1, ess_pkg::ADDR_COOL, 32'h1);
        wb(1, ess_pkg::ADDR_GOVOFS, 32'h55);
        press(4);
        wt(0, 1, 100);
        chk(gout, 16'h0123);
        press(7);
        chk({cool, gbo, run}, 3'h7);
        repeat (60) @(posedge clk);
        chk(coil, 0);
        wt(3, 1, 150);
        chk(inh, 1);
        press(4);
        wt(3, 0, 800);
        repeat (2) @(posedge clk);
        chk({run, gout}, 17'h00055);
        chk(alarm, 0);
    endtask
    task t_estop;
        press(4);
        wt(0, 1, 100);
        press(9);
        chk({cool, coil, gbo}, 3'h3);
        wt(3, 0, 800);
    endtask
    task t_abort;
        wb(1, ess_pkg::ADDR_COOL, 32'h0);
        press(4);
        wt(0, 1, 100);
        press(10);
        repeat (300) @(posedge clk);
        chk({cool, coil}, 2'h2);
        press(4);
        chk({cool, run}, 2'h1);
        press(10);
        press(10);
        chk({cool, coil}, 2'h1);
        wt(3, 0, 800);
    endtask
    task t_feedback;
        wb(1, ess_pkg::ADDR_RUNLVL, 32'hFFFF);
        wb(1, ess_pkg::ADDR_CRANK, 32'h0);
        wb(1, ess_pkg::ADDR_RUNFB, 32'h0);
        wb(1, ess_pkg::ADDR_FV, 32'h0);
        win <= 0;
        press(4);
        repeat (200) @(posedge clk);
        chk(alarm, 5'h07);
        press(10);
        wb(1, ess_pkg::ADDR_THR, 32'h5);
        wt(3, 1, 5);
        win <= 1;
        wt(3, 0, 800);
        wb(1, ess_pkg::ADDR_THR, 32'h0);
        wb(1, ess_pkg::ADDR_RUNLVL, 32'h12C);
        wb(1, ess_pkg::ADDR_ALARM, 32'h1F);
        rc(ess_pkg::ADDR_ALARM, 32'h0);
    endtask
    task t_stuck;
        stuck <= 1;
        press(4);
        wt(0, 1, 100);
        press(10);
        press(10);
        repeat (2800) @(posedge clk);
        chk(alarm[4], 0);
        wt(4, 1, 400);
        stuck <= 0;
        wt(3, 0, 800);
        wb(1, ess_pkg::ADDR_ALARM, 32'h1F);
        rc(ess_pkg::ADDR_ALARM, 32'h0);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 0;
        t_reset;
        t_stop;
        t_estop;
        t_abort;
        t_feedback;
        t_stuck;
        report_and_stop;
    end
endmodule
`default_nettype wire
